// >>> hdl/touch_block_pattern_detect.sv
// Purpose: Signal guard enables, simultaneous touch blocking and multiple touch pattern detection.
// Assumes: The sensing engine raises cycleDone for one clock with one sensing cycle's results.
// Notes:   Register port is the internal byte port behind the serial interface.
// Overview of operation
// - Guard enables sit at bit 2 for input 3, bit 0 for input 1; reset zero.
// - Any enabled guard disables input 2 from sampling and reporting.
// - Blocking enable is bit 7, reset one; cleared means the limit never blocks a touch.
// - With blocking, report up to the limit, keep valid inputs, block others until release.
// - After a release, pick allowed touches in order input 1 to input 3.
// - Limit field bits 3:2 gives 1, 2, 3, 3 touches; reset gives one.
// - Limit flag sets when touches reach the limit and others get blocked.
// - Blocking uses the full threshold; pattern uses a fraction of it.
// - Pattern scale bits 3:2 give 12.5, 25, 37.5 and 100 percent.
// - Reference is the touch threshold in Active, standby threshold in Standby.
// - Pattern enable bit 7 turns detection on; reset zero keeps it off.
// - Pattern mode: every selected input must exceed threshold or show noise.
// - Count mode: qualifying inputs must number at least the selected bit count.
// - Comparisons use one sensing cycle's results only.
// - A pattern event blocks all touch detection and raises an interrupt.
// - Inputs stay blocked while the condition holds, then detection resumes.
// - Pattern flag clears only by a host clear after the condition is gone.
// - Pattern alert enable bit 0 gates the alert; the flag sets regardless.
// - Pattern select bits 2:0 map inputs 3 to 1, reset all ones.
`include "touch_block_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module touch_block_pattern_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData,
  output logic regReadValid,
  // Sensing cycle results
  input wire logic cycleDone,
  input wire logic [touch_block_pkg::NUM_INPUTS-1:0][touch_block_pkg::DELTA_W-1:0] deltaCount,
  input wire logic [touch_block_pkg::NUM_INPUTS-1:0][touch_block_pkg::THRESH_W-1:0] touchThreshold,
  input wire logic [touch_block_pkg::THRESH_W-1:0] standbyThreshold,
  input wire logic [touch_block_pkg::NUM_INPUTS-1:0] standbyInput,
  input wire logic [touch_block_pkg::NUM_INPUTS-1:0] noiseFlag,
  // Interrupt bit clear from the status logic
  input wire logic intClear,
  // Status towards touch status, interrupt and alert logic
  output logic [touch_block_pkg::NUM_INPUTS-1:0] reportedTouch,
  output logic touchLimitFlag,
  output logic patternEventFlag,
  output logic patternActive,
  output logic patternAlertReq,
  // Sense front end controls
  output logic guardEnInput1,
  output logic guardEnInput3,
  output logic sense2Disable
);
  import touch_block_pkg::*;

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  core_state_t state_reg;
  core_state_t state_next;

  // Reset image built from the documented register defaults.
  localparam logic [7:0] GUARD_RST = `GUARD_ENABLE_RESET;
  localparam logic [7:0] MTC_RST = `MULTI_TOUCH_CONFIG_RESET;
  localparam logic [7:0] PDC_RST = `PATTERN_DETECT_CONFIG_RESET;
  localparam logic [7:0] PSEL_RST = `PATTERN_SELECT_RESET;

  localparam core_state_t STATE_RESET = '{
    guardEn: {GUARD_RST[`GUARD_IN3_BIT], 1'b0, GUARD_RST[`GUARD_IN1_BIT]},
    blockEn: MTC_RST[`BLOCK_EN_BIT],
    limitCode: MTC_RST[`LIMIT_MSB:`LIMIT_LSB],
    patEnable: PDC_RST[`PAT_EN_BIT],
    patScale: pattern_scale_t'(PDC_RST[`PAT_SCALE_MSB:`PAT_SCALE_LSB]),
    patMode: pattern_mode_t'(PDC_RST[`PAT_MODE_BIT]),
    patAlertEn: PDC_RST[`PAT_ALERT_BIT],
    patSel: PSEL_RST[`PAT_SEL_MSB:`PAT_SEL_LSB],
    reported: '0,
    limitFlag: 1'b0,
    patActive: 1'b0,
    patFlag: 1'b0,
    alertPulse: 1'b0,
    readData: 8'h00,
    readValid: 1'b0
  };

  // ----------------------------------------------------------------------------
  // Per-input thresholds and comparisons
  // ----------------------------------------------------------------------------
  logic [NUM_INPUTS-1:0][THRESH_W-1:0] refThresh;
  logic [NUM_INPUTS-1:0][THRESH_W-1:0] patThresh;
  logic [NUM_INPUTS-1:0] inputOff;
  logic [NUM_INPUTS-1:0] touchRaw;
  logic [NUM_INPUTS-1:0] qualify;

  // A guard on either outer input takes input 2 away.
  assign sense2Disable = |state_reg.guardEn;

  for (genvar i = 0; i < NUM_INPUTS; i++) begin : gen_input
    // The reference follows the state the input is enabled in.
    assign refThresh[i] = standbyInput[i] ? standbyThreshold : touchThreshold[i];

    pattern_thresh_scale #(
      .TW(THRESH_W)
    ) u_scale (
      .refThresh(refThresh[i]),
      .scale(state_reg.patScale),
      .scaledThresh(patThresh[i])
    );

    assign inputOff[i] = (i == 1) && sense2Disable;

    // Touch uses the full reference, the pattern the scaled one.
    assign touchRaw[i] = !inputOff[i] && (deltaCount[i] > {1'b0, refThresh[i]});
    assign qualify[i] = !inputOff[i] && ((deltaCount[i] > {1'b0, patThresh[i]}) || noiseFlag[i]);
  end

  // ----------------------------------------------------------------------------
  // Simultaneous touch limit
  // ----------------------------------------------------------------------------
  logic [1:0] limitCount;
  logic [NUM_INPUTS-1:0] freshChoice;
  logic [NUM_INPUTS-1:0] heldValid;
  logic noRelease;
  logic [NUM_INPUTS-1:0] allowed;

  // Code 11 repeats the three-touch limit.
  always_comb begin
    unique case (state_reg.limitCode)
      2'b00: limitCount = 2'h1;
      2'b01: limitCount = 2'h2;
      2'b10: limitCount = 2'h3;
      2'b11: limitCount = 2'h3;
    endcase
  end

  touch_limit_select #(
    .N(NUM_INPUTS)
  ) u_select (
    .touches(touchRaw),
    .limit(limitCount),
    .chosen(freshChoice)
  );

  // Previously reported pads that are still touched stay valid.
  assign heldValid = state_reg.reported & touchRaw;
  assign noRelease = (state_reg.reported != '0) && (heldValid == state_reg.reported);

  // Old set kept until a reported pad lets go; then a fresh choice in order.
  always_comb begin
    if (!state_reg.blockEn) begin
      allowed = touchRaw;
    end else if (noRelease) begin
      allowed = heldValid;
    end else begin
      allowed = freshChoice;
    end
  end

  // ----------------------------------------------------------------------------
  // Pattern condition
  // ----------------------------------------------------------------------------
  logic [1:0] qualifyCount;
  logic [1:0] selectCount;
  logic patternMatch;
  logic countMatch;
  logic patCond;
  logic patEvent;

  // Population counts of three bits fit two bits.
  assign qualifyCount = 2'({1'b0, qualify[0]} + {1'b0, qualify[1]} + {1'b0, qualify[2]});
  assign selectCount = 2'({1'b0, state_reg.patSel[0]} + {1'b0, state_reg.patSel[1]}
    + {1'b0, state_reg.patSel[2]});

  // An empty selection never fires, else it would match every cycle.
  assign patternMatch = (state_reg.patSel != '0) && ((qualify & state_reg.patSel) == state_reg.patSel);
  assign countMatch = (selectCount != 2'h0) && (qualifyCount >= selectCount);

  always_comb begin
    unique case (state_reg.patMode)
      MODE_PATTERN: patCond = state_reg.patEnable && patternMatch;
      MODE_COUNT: patCond = state_reg.patEnable && countMatch;
    endcase
  end

  // A new event is the first cycle of the condition.
  assign patEvent = cycleDone && patCond && !state_reg.patActive;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.alertPulse = 1'b0;
    state_next.readValid = 1'b0;

    // Register writes; unused bits are dropped.
    if (regWrite) begin
      unique case (regAddr)
        `GUARD_ENABLE_ADDR: begin
          state_next.guardEn = {regWriteData[`GUARD_IN3_BIT], 1'b0, regWriteData[`GUARD_IN1_BIT]};
        end
        `MULTI_TOUCH_CONFIG_ADDR: begin
          state_next.blockEn = regWriteData[`BLOCK_EN_BIT];
          state_next.limitCode = regWriteData[`LIMIT_MSB:`LIMIT_LSB];
        end
        `PATTERN_DETECT_CONFIG_ADDR: begin
          state_next.patEnable = regWriteData[`PAT_EN_BIT];
          state_next.patScale = pattern_scale_t'(regWriteData[`PAT_SCALE_MSB:`PAT_SCALE_LSB]);
          state_next.patMode = pattern_mode_t'(regWriteData[`PAT_MODE_BIT]);
          state_next.patAlertEn = regWriteData[`PAT_ALERT_BIT];
        end
        `PATTERN_SELECT_ADDR: begin
          state_next.patSel = regWriteData[`PAT_SEL_MSB:`PAT_SEL_LSB];
        end
        default: begin
        end
      endcase
    end

    // Register reads answer one cycle later; unused bits and other offsets give zero.
    if (regRead) begin
      state_next.readValid = 1'b1;
      state_next.readData = 8'h00;
      unique case (regAddr)
        `GUARD_ENABLE_ADDR: begin
          state_next.readData[`GUARD_IN3_BIT] = state_reg.guardEn[2];
          state_next.readData[`GUARD_IN1_BIT] = state_reg.guardEn[0];
        end
        `MULTI_TOUCH_CONFIG_ADDR: begin
          state_next.readData[`BLOCK_EN_BIT] = state_reg.blockEn;
          state_next.readData[`LIMIT_MSB:`LIMIT_LSB] = state_reg.limitCode;
        end
        `PATTERN_DETECT_CONFIG_ADDR: begin
          state_next.readData[`PAT_EN_BIT] = state_reg.patEnable;
          state_next.readData[`PAT_SCALE_MSB:`PAT_SCALE_LSB] = state_reg.patScale;
          state_next.readData[`PAT_MODE_BIT] = state_reg.patMode;
          state_next.readData[`PAT_ALERT_BIT] = state_reg.patAlertEn;
        end
        `PATTERN_SELECT_ADDR: begin
          state_next.readData[`PAT_SEL_MSB:`PAT_SEL_LSB] = state_reg.patSel;
        end
        default: begin
        end
      endcase
    end

    // Host clear is honoured only once the condition has gone away.
    if (intClear && !state_reg.patActive) begin
      state_next.patFlag = 1'b0;
    end

    // One evaluation per sensing cycle; the reported set and pattern state carry over to the next.
    if (cycleDone) begin
      state_next.patActive = patCond;
      if (patCond) begin
        // Every input is blocked for as long as the condition stands.
        state_next.reported = '0;
        state_next.limitFlag = 1'b0;
      end else begin
        state_next.reported = allowed;
        state_next.limitFlag = state_reg.blockEn && ((touchRaw & ~allowed) != '0);
      end
      if (patCond) begin
        // Setting beats a clear arriving in the same clock.
        state_next.patFlag = 1'b1;
      end
    end

    // The alert request follows only a new event, and only when enabled.
    if (patEvent && state_reg.patAlertEn) begin
      state_next.alertPulse = 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  // All come straight from the state register.
  assign regReadData = state_reg.readData;
  assign regReadValid = state_reg.readValid;
  assign reportedTouch = state_reg.reported;
  assign touchLimitFlag = state_reg.limitFlag;
  assign patternEventFlag = state_reg.patFlag;
  assign patternActive = state_reg.patActive;
  assign patternAlertReq = state_reg.alertPulse;
  assign guardEnInput1 = state_reg.guardEn[0];
  assign guardEnInput3 = state_reg.guardEn[2];
endmodule
`default_nettype wire

// >>> hdl/touch_block_cfg.svh
// Purpose: Register offsets, field positions and reset values of the touch blocking and pattern block.
// Assumes: Eight-bit registers reached through the device's own serial register port.
// Notes:   Definitions only; included by bare name.
`ifndef TOUCH_BLOCK_CFG_SVH
`define TOUCH_BLOCK_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define GUARD_ENABLE_ADDR 8'h29
`define MULTI_TOUCH_CONFIG_ADDR 8'h2a
`define PATTERN_DETECT_CONFIG_ADDR 8'h2b
`define PATTERN_SELECT_ADDR 8'h2d

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define GUARD_ENABLE_RESET 8'h00
`define MULTI_TOUCH_CONFIG_RESET 8'h80
`define PATTERN_DETECT_CONFIG_RESET 8'h00
`define PATTERN_SELECT_RESET 8'h07

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define GUARD_IN1_BIT 0
`define GUARD_IN3_BIT 2
`define BLOCK_EN_BIT 7
`define LIMIT_LSB 2
`define LIMIT_MSB 3
`define PAT_EN_BIT 7
`define PAT_SCALE_LSB 2
`define PAT_SCALE_MSB 3
`define PAT_MODE_BIT 1
`define PAT_ALERT_BIT 0
`define PAT_SEL_LSB 0
`define PAT_SEL_MSB 2

`endif

// >>> hdl/touch_block_pkg.sv
// Purpose: Types shared by the touch blocking and pattern detection design.
// Assumes: Three sense inputs, index 0 is input 1.
// Notes:   Register numbers live in touch_block_cfg.svh; this package holds the sizes and types.
package touch_block_pkg;

  // ----------------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------------
  localparam int NUM_INPUTS = 3;
  localparam int DELTA_W = 8;
  localparam int THRESH_W = 7;

  // ----------------------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------------------
  // Order matches the field codes 00, 01, 10, 11.
  typedef enum logic [1:0] {SCALE_12P5, SCALE_25, SCALE_37P5, SCALE_100} pattern_scale_t;
  typedef enum logic {MODE_COUNT, MODE_PATTERN} pattern_mode_t;

  // ----------------------------------------------------------------------------
  // State of the top module
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [NUM_INPUTS-1:0] guardEn;
    logic blockEn;
    logic [1:0] limitCode;
    logic patEnable;
    pattern_scale_t patScale;
    pattern_mode_t patMode;
    logic patAlertEn;
    logic [NUM_INPUTS-1:0] patSel;
    logic [NUM_INPUTS-1:0] reported;
    logic limitFlag;
    logic patActive;
    logic patFlag;
    logic alertPulse;
    logic [7:0] readData;
    logic readValid;
  } core_state_t;

endpackage

// >>> hdl/pattern_thresh_scale.sv
// Purpose: Scales one reference threshold by the pattern threshold code.
// Assumes: Reference already chosen between the touch and standby threshold.
// Notes:   Purely combinational; shifts avoid a multiplier.
`timescale 1ns/1ps
`default_nettype none
module pattern_thresh_scale #(
  parameter int TW = 7
) (
  // Reference and code
  input wire logic [TW-1:0] refThresh,
  input wire touch_block_pkg::pattern_scale_t scale,
  // Scaled threshold
  output logic [TW-1:0] scaledThresh
);
  import touch_block_pkg::*;

  // Eighths by shifts; 37.5% is a quarter plus an eighth, never overflowing.
  always_comb begin
    unique case (scale)
      SCALE_12P5: scaledThresh = refThresh >> 3;
      SCALE_25: scaledThresh = refThresh >> 2;
      SCALE_37P5: scaledThresh = (refThresh >> 2) + (refThresh >> 3);
      SCALE_100: scaledThresh = refThresh;
    endcase
  end
endmodule
`default_nettype wire

// >>> hdl/touch_limit_select.sv
// Purpose: Picks the first touches, in sensing order, up to a limit.
// Assumes: Index 0 is sensed first.
// Notes:   A running count ripples across the inputs; fine for three inputs.
`timescale 1ns/1ps
`default_nettype none
module touch_limit_select #(
  parameter int N = 3
) (
  // Candidates and limit
  input wire logic [N-1:0] touches,
  input wire logic [1:0] limit,
  // Allowed set
  output logic [N-1:0] chosen
);
  import touch_block_pkg::*;

  logic [1:0] runCount [N+1];

  assign runCount[0] = 2'h0;

  // Each input is taken only while the running count is below the limit.
  for (genvar i = 0; i < N; i++) begin : gen_pick
    assign chosen[i] = touches[i] && (runCount[i] < limit);
    assign runCount[i+1] = runCount[i] + {1'b0, chosen[i]};
  end
endmodule
`default_nettype wire

// >>> tb/touch_block_pattern_detect_properties.sv
// Purpose: Concurrent checks on the ports of the touch blocking and pattern block.
// Assumes: One clock domain; reported touches, limit flag and pattern active move only on sensing cycle results.
// Notes:   Attached by bind from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module touch_block_pattern_detect_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regReadValid,
  // Sensing and clear
  input wire logic cycleDone,
  input wire logic intClear,
  // Status and front end
  input wire logic [touch_block_pkg::NUM_INPUTS-1:0] reportedTouch,
  input wire logic touchLimitFlag,
  input wire logic patternEventFlag,
  input wire logic patternActive,
  input wire logic patternAlertReq,
  input wire logic guardEnInput1,
  input wire logic guardEnInput3,
  input wire logic sense2Disable
);
  import touch_block_pkg::*;

  // ----------------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------------
  // One clock domain: defaults set once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_read_latency: assert property (regRead |=> regReadValid)
    else $error("read answer missing");
  a_read_unasked: assert property (!regRead |=> !regReadValid)
    else $error("unasked read answer");
  a_guard_write: assert property (regWrite && regAddr == 8'h29 |=>
    guardEnInput1 == $past(regWriteData[0]) && guardEnInput3 == $past(regWriteData[2]))
    else $error("guard enables wrong");
  a_sense2_off: assert property (sense2Disable == (guardEnInput1 || guardEnInput3))
    else $error("input 2 disable wrong");
  a_status_hold: assert property (!cycleDone |=> $stable(reportedTouch) &&
    $stable(touchLimitFlag) && $stable(patternActive))
    else $error("status moved between cycles");
  a_pattern_blocks: assert property (patternActive |-> reportedTouch == 3'h0 && !touchLimitFlag)
    else $error("touches reported during pattern");
  a_alert_pulse: assert property (patternAlertReq |-> patternActive && !$past(patternActive)
    ##1 !patternAlertReq)
    else $error("bad alert pulse");
  a_flag_set: assert property (patternActive |-> patternEventFlag)
    else $error("pattern flag low");
  a_flag_clear: assert property ($fell(patternEventFlag) |-> $past(intClear) && !$past(patternActive))
    else $error("illegal flag clear");
  a_limit_reports: assert property (touchLimitFlag |-> reportedTouch != 3'h0)
    else $error("limit flag with no report");

  // Main scenarios seen at least once.
  c_alert: cover property (cycleDone ##1 patternAlertReq);
  c_limit: cover property (touchLimitFlag);
  c_clear: cover property ($fell(patternEventFlag));
endmodule
`default_nettype wire

// >>> tb/touch_host_model.sv
// Purpose: Host side of the internal register port, one byte per strobe.
// Assumes: Strobes last one cycle.
// Notes:   Released address and data show inverted values.
`timescale 1ns/1ps
`default_nettype none
module touch_host_model (
  // Clock
  input wire logic clk,
  // Register port towards the block
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWriteData
);
  // Idle port at time zero.
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWriteData = 8'h00;
  end

  // One byte written.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWriteData <= ~d;
  endtask

  // One byte read; the monitor takes the answer.
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    regAddr <= ~a;
  endtask
endmodule
`default_nettype wire

// >>> tb/touch_block_pattern_detect_bench.sv
// Purpose: Self-checking bench of register map, touch blocking and pattern detection.
// Assumes: Touch thresholds 64, standby threshold 32; expectations noted in queues.
// Notes:   Deltas between sensing pulses are inverted.
`include "touch_block_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin nErrors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, s); end end
module touch_block_pattern_detect_bench;
  import touch_block_pkg::*;

  // ----------------------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------------------
  logic clk = 1'b0;
  logic arst_n, regWrite, regRead, regReadValid, cycleDone, intClear;
  logic [7:0] regAddr, regWriteData, regReadData, eR;
  logic [2:0][7:0] deltaCount;
  logic [2:0][6:0] touchThreshold;
  logic [6:0] standbyThreshold, eS;
  logic [2:0] standbyInput, noiseFlag, reportedTouch;
  logic touchLimitFlag, patternEventFlag, patternActive, patternAlertReq;
  logic guardEnInput1, guardEnInput3, sense2Disable;
  logic cycD = 1'b0;
  logic eflag = 1'b0;
  logic lastAct = 1'b0;
  logic [7:0] rdQ[$];
  logic [6:0] stQ[$];
  int nErrors = 0;
  int checked = 0;
  int seed = 32'hbb77_9c05;
  int n;
  logic [7:0] ad [5] = '{`GUARD_ENABLE_ADDR, `MULTI_TOUCH_CONFIG_ADDR, `PATTERN_DETECT_CONFIG_ADDR,
    `PATTERN_SELECT_ADDR, 8'h2c};
  logic [7:0] rv [5] = '{`GUARD_ENABLE_RESET, `MULTI_TOUCH_CONFIG_RESET, `PATTERN_DETECT_CONFIG_RESET,
    `PATTERN_SELECT_RESET, 8'h00};
  logic [7:0] mv [5] = '{8'h05, 8'h8c, 8'h8f, 8'h07, 8'h00};
  logic [7:0] st [4] = '{8'h08, 8'h10, 8'h18, 8'h40};

  always #2.5 clk = ~clk;

  touch_block_pattern_detect uut (.clk, .arst_n, .regWrite, .regRead, .regAddr, .regWriteData,
    .regReadData, .regReadValid, .cycleDone, .deltaCount, .touchThreshold, .standbyThreshold,
    .standbyInput, .noiseFlag, .intClear, .reportedTouch, .touchLimitFlag, .patternEventFlag,
    .patternActive, .patternAlertReq, .guardEnInput1, .guardEnInput3, .sense2Disable);
  touch_host_model host (.clk, .regWrite, .regRead, .regAddr, .regWriteData);

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // Random delta: above 64 when touched, at most 63 otherwise.
  function automatic logic [7:0] rnd(input logic t);
    rnd = t ? 8'h41 + 8'($random(seed) & 63) : 8'($random(seed) & 63);
  endfunction
  function automatic logic [2:0][7:0] mk(input logic [2:0] t);
    mk = {rnd(t[2]), rnd(t[1]), rnd(t[0])};
  endfunction

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rdQ.push_back(e);
    host.rd(a);
  endtask

  // One sensing cycle; expected flag sticks until a legal clear.
  task automatic sense(input logic [2:0][7:0] d, input logic [2:0] nz, input logic [2:0] sb,
      input logic [2:0] rep, input logic lim, input logic act, input logic al);
    @(posedge clk);
    cycleDone <= 1'b1;
    deltaCount <= d;
    noiseFlag <= nz;
    standbyInput <= sb;
    eflag = eflag | act;
    stQ.push_back({rep, lim, act, eflag, al});
    lastAct = act;
    @(posedge clk);
    cycleDone <= 1'b0;
    deltaCount <= ~d;
    noiseFlag <= ~nz;
  endtask

  task automatic clr();
    @(posedge clk);
    intClear <= 1'b1;
    @(posedge clk);
    intClear <= 1'b0;
    if (!lastAct) eflag = 1'b0;
  endtask

  task automatic rest();
    sense(24'h00_0000, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0);
    clr();
  endtask

  task automatic wrap_up();
    if (nErrors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Monitor: each answer takes the oldest note of its kind.
  always @(posedge clk) begin
    if (regReadValid === 1'b1) begin
      eR = rdQ.pop_front();
      `CHK("regReadData", eR, regReadData)
    end
    if (cycD) begin
      eS = stQ.pop_front();
      `CHK("status", eS, {reportedTouch, touchLimitFlag, patternActive, patternEventFlag, patternAlertReq})
    end
    cycD <= cycleDone;
  end

  // Watchdog far beyond the few hundred cycles needed.
  initial begin
    #50000;
    nErrors++;
    wrap_up();
  end

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    cycleDone = 1'b0;
    deltaCount = '0;
    touchThreshold = {3{7'h40}};
    standbyThreshold = 7'h20;
    standbyInput = 3'h0;
    noiseFlag = 3'h0;
    intClear = 1'b0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    // Reset values, unused bit masks, an unmapped offset, defaults back.
    for (int i = 0; i < 5; i++) rd(ad[i], rv[i]);
    for (int i = 0; i < 5; i++) host.wr(ad[i], 8'hff);
    for (int i = 0; i < 5; i++) rd(ad[i], mv[i]);
    for (int i = 0; i < 5; i++) host.wr(ad[i], rv[i]);
    // Guard on input 1 turns input 2 off.
    host.wr(`GUARD_ENABLE_ADDR, 8'h01);
    @(negedge clk);
    `CHK("sense2Disable", 1'b1, sense2Disable)
    sense(mk(3'h2), 3'h0, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0);
    host.wr(`GUARD_ENABLE_ADDR, 8'h00);
    // Limit one: first touch kept, next in order after a release.
    sense(mk(3'h7), 3'h0, 3'h0, 3'h1, 1'b1, 1'b0, 1'b0);
    sense(mk(3'h7), 3'h0, 3'h0, 3'h1, 1'b1, 1'b0, 1'b0);
    sense(mk(3'h6), 3'h0, 3'h0, 3'h2, 1'b1, 1'b0, 1'b0);
    for (int c = 0; c < 4; c++) begin
      n = (c == 0) ? 1 : ((c == 1) ? 2 : 3);
      host.wr(`MULTI_TOUCH_CONFIG_ADDR, 8'h80 | 8'(c << 2));
      sense(mk(3'h0), 3'h0, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0);
      sense(mk(3'h7), 3'h0, 3'h0, 3'((1 << n) - 1), n < 3, 1'b0, 1'b0);
    end
    host.wr(`MULTI_TOUCH_CONFIG_ADDR, 8'h00);
    sense(mk(3'h7), 3'h0, 3'h0, 3'h7, 1'b0, 1'b0, 1'b0);
    host.wr(`MULTI_TOUCH_CONFIG_ADDR, 8'h80);
    // Scale codes, count mode, input 1: equal delta misses.
    host.wr(`PATTERN_SELECT_ADDR, 8'h01);
    for (int s = 0; s < 4; s++) begin
      host.wr(`PATTERN_DETECT_CONFIG_ADDR, 8'h80 | 8'(s << 2));
      sense({16'h0000, st[s]}, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0);
      sense({16'h0000, st[s] + 8'h01}, 3'h0, 3'h0, 3'h0, 1'b0, 1'b1, 1'b0);
      rest();
    end
    // Standby reference 32 gives a threshold of 4.
    host.wr(`PATTERN_DETECT_CONFIG_ADDR, 8'h80);
    sense(24'h00_0004, 3'h0, 3'h1, 3'h0, 1'b0, 1'b0, 1'b0);
    sense(24'h00_0005, 3'h0, 3'h1, 3'h0, 1'b0, 1'b1, 1'b0);
    rest();
    // Pattern mode on inputs 1 and 3 (3 by noise), alert on.
    host.wr(`PATTERN_SELECT_ADDR, 8'h05);
    host.wr(`PATTERN_DETECT_CONFIG_ADDR, 8'h83);
    sense(24'h00_0046, 3'h4, 3'h0, 3'h0, 1'b0, 1'b1, 1'b1);
    clr();
    sense(24'h00_0046, 3'h4, 3'h0, 3'h0, 1'b0, 1'b1, 1'b0);
    sense(24'h00_0046, 3'h0, 3'h0, 3'h1, 1'b0, 1'b0, 1'b0);
    clr();
    // Count mode: two qualifying inputs meet two selected bits.
    host.wr(`PATTERN_DETECT_CONFIG_ADDR, 8'h81);
    sense(24'h00_0909, 3'h0, 3'h0, 3'h0, 1'b0, 1'b1, 1'b1);
    rest();
    // Detection off: the same inputs raise nothing.
    host.wr(`PATTERN_DETECT_CONFIG_ADDR, 8'h03);
    sense(24'h00_0909, 3'h7, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule

bind touch_block_pattern_detect touch_block_pattern_detect_properties chk (.clk, .arst_n, .regWrite,
  .regRead, .regAddr, .regWriteData, .regReadValid, .cycleDone, .intClear, .reportedTouch,
  .touchLimitFlag, .patternEventFlag, .patternActive, .patternAlertReq, .guardEnInput1,
  .guardEnInput3, .sense2Disable);
`default_nettype wire
